// File: design/dpm_top.sv
// control state of a dual pll clock synthesizer, reverse/slave setup
module dpm_top (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic cfg_wr,
  input wire logic [dpm_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic [dpm_pkg::REG_W-1:0] cfg_wdata,
  output logic [dpm_pkg::REG_W-1:0] cfg_rdata,
  input wire logic rate_family_select,
  input wire logic pll1_lock_pin,
  input wire logic pll2_lock_pin,
  input wire logic pll1_clk_pin,
  input wire logic pll2_clk_pin,
  input wire logic sync_pin,
  output logic slave_mode,
  output logic rev_slave_mode,
  output logic [3:0] mode_code,
  output logic [3:0] multiplier,
  output logic first_pll_enable,
  output logic second_pll_enable,
  output logic [dpm_pkg::REG_W-1:0] third_cfg,
  output logic [dpm_pkg::REG_W-1:0] fourth_cfg,
  output logic primary_clock_out,
  output logic secondary_clock_out,
  output logic sync_out,
  output logic lock_indicator
);
  import dpm_pkg::*;

  logic [REG_W-1:0] mode_and_pll1_ctrl_q;
  logic [REG_W-1:0] multiplier_and_pll2_ctrl_q;
  logic [REG_W-1:0] third_command_register_q;
  logic [REG_W-1:0] fourth_command_register_q;
  logic [REG_W-1:0] output_enable_ctrl_q;
  logic [REG_W-1:0] rdata_q;
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic slave_q, rev_q;
  logic [3:0] mode_q, mult_q;
  logic en1_q, en2_q;
  logic [REG_W-1:0] third_q, fourth_q;
  logic pri_clk_q, sec_clk_q, sync_q, lock_q;

  assign pins_raw = {sync_pin, pll2_clk_pin, pll1_clk_pin, pll2_lock_pin, pll1_lock_pin,
                     rate_family_select};

  dpm_sync #(
    .W(PIN_W)
  ) u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .ce(ce),
    .pin_in(pins_raw),
    .pin_sync(pins_s)
  );

  // register decode
  wire wr_mode = cfg_wr && (cfg_addr == ADDR_MODE_PLL1);
  wire wr_mult = cfg_wr && (cfg_addr == ADDR_MULT_PLL2);
  wire wr_third = cfg_wr && (cfg_addr == ADDR_THIRD);
  wire wr_fourth = cfg_wr && (cfg_addr == ADDR_FOURTH);
  wire wr_out = cfg_wr && (cfg_addr == ADDR_OUT_EN);

  // unmapped addresses read zero
  wire [REG_W-1:0] rdata_d =
    (cfg_addr == ADDR_MODE_PLL1) ? mode_and_pll1_ctrl_q :
    (cfg_addr == ADDR_MULT_PLL2) ? multiplier_and_pll2_ctrl_q :
    (cfg_addr == ADDR_THIRD) ? third_command_register_q :
    (cfg_addr == ADDR_FOURTH) ? fourth_command_register_q :
    (cfg_addr == ADDR_OUT_EN) ? output_enable_ctrl_q : REG_RESET;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_and_pll1_ctrl_q <= REG_RESET;
      multiplier_and_pll2_ctrl_q <= REG_RESET;
      third_command_register_q <= REG_RESET;
      fourth_command_register_q <= REG_RESET;
      output_enable_ctrl_q <= REG_RESET;
      rdata_q <= REG_RESET;
    end else if (ce) begin
      if (wr_mode) mode_and_pll1_ctrl_q <= cfg_wdata;
      if (wr_mult) multiplier_and_pll2_ctrl_q <= cfg_wdata;
      if (wr_third) third_command_register_q <= cfg_wdata;
      if (wr_fourth) fourth_command_register_q <= cfg_wdata;
      if (wr_out) output_enable_ctrl_q <= cfg_wdata;
      rdata_q <= rdata_d;
    end
  end

  // field extraction
  wire [3:0] mode_f = mode_and_pll1_ctrl_q[FIELD_HI:FIELD_LO];
  wire [3:0] mult_f = multiplier_and_pll2_ctrl_q[FIELD_HI:FIELD_LO];
  wire en1_f = mode_and_pll1_ctrl_q[PLL_EN_BIT];
  wire en2_f = multiplier_and_pll2_ctrl_q[PLL_EN_BIT];
  wire sync_en_f = output_enable_ctrl_q[SYNC_EN_BIT];
  wire pri_en_f = output_enable_ctrl_q[PRI_CLK_EN_BIT];
  wire sec_en_f = output_enable_ctrl_q[SEC_CLK_EN_BIT];
  wire [1:0] lock_sel_f = {output_enable_ctrl_q[LOCK2_SEL_BIT],
                           output_enable_ctrl_q[LOCK1_SEL_BIT]};

  wire slave_d = !pins_s[PIN_MS];
  // mode code only counts in slave
  wire rev_d = slave_d && (mode_f == MODE_REV_SLAVE);
  // reverse/slave hides the third and fourth registers from the loops
  wire [REG_W-1:0] third_d = rev_d ? REG_RESET : third_command_register_q;
  wire [REG_W-1:0] fourth_d = rev_d ? REG_RESET : fourth_command_register_q;

  wire lock1 = pins_s[PIN_LOCK1];
  wire lock2 = pins_s[PIN_LOCK2];
  // in the both selection a disabled pll does not hold the indicator low; none enabled reads low
  wire both_ok = (en1_f || en2_f) && (!en1_f || lock1) && (!en2_f || lock2);
  wire lock_d = (lock_sel_f == LOCK_SEL_BOTH) ? both_ok :
                (lock_sel_f == LOCK_SEL_FIRST) ? lock1 :
                (lock_sel_f == LOCK_SEL_SECOND) ? lock2 : 1'b0;

  // loop clocks reach the pins only with pll and driver enabled
  wire pri_clk_d = pins_s[PIN_PRI_CLK] && en1_f && pri_en_f;
  wire sec_clk_d = pins_s[PIN_SEC_CLK] && en2_f && sec_en_f;
  wire sync_d = pins_s[PIN_SYNC] && sync_en_f;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      slave_q <= 1'b0;
      rev_q <= 1'b0;
      mode_q <= 4'h0;
      mult_q <= 4'h0;
      en1_q <= 1'b0;
      en2_q <= 1'b0;
      third_q <= REG_RESET;
      fourth_q <= REG_RESET;
      pri_clk_q <= 1'b0;
      sec_clk_q <= 1'b0;
      sync_q <= 1'b0;
      lock_q <= 1'b0;
    end else if (ce) begin
      slave_q <= slave_d;
      rev_q <= rev_d;
      mode_q <= mode_f;
      mult_q <= mult_f;
      en1_q <= en1_f;
      en2_q <= en2_f;
      third_q <= third_d;
      fourth_q <= fourth_d;
      pri_clk_q <= pri_clk_d;
      sec_clk_q <= sec_clk_d;
      sync_q <= sync_d;
      lock_q <= lock_d;
    end
  end

  // multiplier passes to the loop as written; host supplies 0000
  assign multiplier = mult_q;
  assign cfg_rdata = rdata_q;
  assign slave_mode = slave_q;
  assign rev_slave_mode = rev_q;
  assign mode_code = mode_q;
  assign first_pll_enable = en1_q;
  assign second_pll_enable = en2_q;
  assign third_cfg = third_q;
  assign fourth_cfg = fourth_q;
  assign primary_clock_out = pri_clk_q;
  assign secondary_clock_out = sec_clk_q;
  assign sync_out = sync_q;
  assign lock_indicator = lock_q;

  // checks
  property p_slave_pin;
    @(posedge core_clk) disable iff (!arst_n)
    // first edge after release still shows the reset value
    ($past(ce) && $past(arst_n)) |-> (slave_mode == !$past(pins_s[PIN_MS]));
  endproperty
  a_slave_pin: assert property (p_slave_pin) else $error("slave flag wrong");

  property p_rev_mode;
    @(posedge core_clk) disable iff (!arst_n)
    rev_slave_mode |-> (slave_mode && mode_code == MODE_REV_SLAVE);
  endproperty
  a_rev_mode: assert property (p_rev_mode) else $error("reverse mode without cause");

  property p_pri_gate;
    @(posedge core_clk) disable iff (!arst_n)
    primary_clock_out |-> ($past(en1_f) && $past(pri_en_f));
  endproperty
  a_pri_gate: assert property (p_pri_gate) else $error("primary clock ungated");

  property p_sec_gate;
    @(posedge core_clk) disable iff (!arst_n)
    secondary_clock_out |-> ($past(en2_f) && $past(sec_en_f));
  endproperty
  a_sec_gate: assert property (p_sec_gate) else $error("secondary clock ungated");

  property p_ignore_regs;
    @(posedge core_clk) disable iff (!arst_n)
    rev_slave_mode |-> (third_cfg == REG_RESET && fourth_cfg == REG_RESET);
  endproperty
  a_ignore_regs: assert property (p_ignore_regs) else $error("third/fourth leak");

  property p_write_read;
    @(posedge core_clk) disable iff (!arst_n)
    (ce && wr_out) ##1 (ce && !cfg_wr && cfg_addr == ADDR_OUT_EN) |=>
      cfg_rdata == $past(cfg_wdata, 2);
  endproperty
  a_write_read: assert property (p_write_read) else $error("readback mismatch");

  property p_lock_low;
    @(posedge core_clk) disable iff (!arst_n)
    ($past(ce) && $past(lock_sel_f) == LOCK_SEL_LOW) |-> !lock_indicator;
  endproperty
  a_lock_low: assert property (p_lock_low) else $error("indicator not forced low");

  property p_lock_both;
    @(posedge core_clk) disable iff (!arst_n)
    ($past(ce) && $past(lock_sel_f) == LOCK_SEL_BOTH && $past(en1_f) && !$past(lock1))
      |-> !lock_indicator;
  endproperty
  a_lock_both: assert property (p_lock_both) else $error("indicator high while unlocked");

  property p_lock_first;
    @(posedge core_clk) disable iff (!arst_n)
    ($past(ce) && $past(lock_sel_f) == LOCK_SEL_FIRST) |-> lock_indicator == $past(lock1);
  endproperty
  a_lock_first: assert property (p_lock_first) else $error("first-only indicator wrong");

  property p_sync_off;
    @(posedge core_clk) disable iff (!arst_n)
    (!sync_en_f)[*2] |=> !sync_out;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync toggles while off");

  c_rev_mode: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(rev_slave_mode));
  c_pri_on: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(primary_clock_out));
  c_lock_up: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(lock_indicator));
endmodule

// File: design/dpm_pkg.sv
// constants for the dual pll mode configuration block
package dpm_pkg;
  localparam int unsigned REG_W = 5;
  localparam int unsigned ADDR_W = 3;
  // register addresses
  localparam logic [2:0] ADDR_MODE_PLL1 = 3'h0;
  localparam logic [2:0] ADDR_MULT_PLL2 = 3'h1;
  localparam logic [2:0] ADDR_THIRD = 3'h2;
  localparam logic [2:0] ADDR_FOURTH = 3'h3;
  localparam logic [2:0] ADDR_OUT_EN = 3'h4;
  // field positions
  localparam int unsigned PLL_EN_BIT = 0;
  localparam int unsigned FIELD_LO = 1;
  localparam int unsigned FIELD_HI = 4;
  localparam int unsigned SYNC_EN_BIT = 4;
  localparam int unsigned PRI_CLK_EN_BIT = 3;
  localparam int unsigned SEC_CLK_EN_BIT = 2;
  localparam int unsigned LOCK2_SEL_BIT = 1;
  localparam int unsigned LOCK1_SEL_BIT = 0;
  // mode and multiplier codes for reverse/slave operation
  localparam logic [3:0] MODE_REV_SLAVE = 4'h8;
  localparam logic [3:0] MULT_REV_SLAVE = 4'h0;
  // lock indicator selections, {second, first}
  localparam logic [1:0] LOCK_SEL_BOTH = 2'h3;
  localparam logic [1:0] LOCK_SEL_FIRST = 2'h1;
  localparam logic [1:0] LOCK_SEL_SECOND = 2'h2;
  localparam logic [1:0] LOCK_SEL_LOW = 2'h0;
  // values after reset
  localparam logic [4:0] REG_RESET = 5'h00;
  // frequencies of the reverse/slave setup, in Hz
  localparam int unsigned REF_FREQ_HZ = 8000;
  localparam int unsigned OUT_FREQ_HZ = 1544000;
  // pin synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;
  // synchronised pin vector layout
  localparam int unsigned PIN_MS = 0;
  localparam int unsigned PIN_LOCK1 = 1;
  localparam int unsigned PIN_LOCK2 = 2;
  localparam int unsigned PIN_PRI_CLK = 3;
  localparam int unsigned PIN_SEC_CLK = 4;
  localparam int unsigned PIN_SYNC = 5;
  localparam int unsigned PIN_W = 6;
endpackage

// File: design/dpm_sync.sv
// two flip-flop synchroniser for a vector of unrelated pins
module dpm_sync #(
  parameter int unsigned W = 1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);
  import dpm_pkg::*;

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else if (ce) begin
        meta_q[i] <= pin_in[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign pin_sync = sync_q;
endmodule

// File: sim/dpm_host_model.sv
// host controller model for the register write port
module dpm_host_model (
  input wire logic core_clk,
  output logic cfg_wr,
  output logic [dpm_pkg::ADDR_W-1:0] cfg_addr,
  output logic [dpm_pkg::REG_W-1:0] cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import dpm_pkg::*;
  initial begin
    cfg_wr = 1'b0;
    cfg_addr = 3'h0;
    cfg_wdata = 5'h00;
  end
  task automatic write_reg(input logic [2:0] a, input logic [4:0] d, input int gap);
    @(posedge core_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    // released data must not look still valid
    cfg_wdata <= ~d;
    repeat (gap) @(posedge core_clk);
  endtask
  task automatic set_addr(input logic [2:0] a);
    @(posedge core_clk);
    cfg_addr <= a;
  endtask
  task automatic rev_slave_setup();
    write_reg(ADDR_MODE_PLL1, {MODE_REV_SLAVE, 1'b1}, 0);
    write_reg(ADDR_MULT_PLL2, {MULT_REV_SLAVE, 1'b1}, 1);
    write_reg(ADDR_THIRD, 5'h1f, 0);
    write_reg(ADDR_FOURTH, 5'h1f, 0);
    write_reg(ADDR_OUT_EN, 5'h1f, 0);
  endtask
endmodule

// File: sim/testbench.sv
// self-checking bench for the dual pll mode configuration block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dpm_pkg::*;
  logic core_clk, arst_n, ce, cfg_wr, rfs, l1, l2, c1, c2, sp;
  logic [ADDR_W-1:0] cfg_addr;
  logic [REG_W-1:0] cfg_wdata, cfg_rdata, third_cfg, fourth_cfg;
  logic slave_mode, rev_slave_mode, first_pll_enable, second_pll_enable;
  logic primary_clock_out, secondary_clock_out, sync_out, lock_indicator;
  logic [3:0] mode_code, multiplier;
  int mismatches, n_tests;
  int m[8];

  dpm_host_model host (.core_clk(core_clk), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata));
  dpm_top dut (.core_clk(core_clk), .arst_n(arst_n), .ce(ce), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .rate_family_select(rfs), .pll1_lock_pin(l1), .pll2_lock_pin(l2),
    .pll1_clk_pin(c1), .pll2_clk_pin(c2), .sync_pin(sp), .slave_mode(slave_mode),
    .rev_slave_mode(rev_slave_mode), .mode_code(mode_code), .multiplier(multiplier),
    .first_pll_enable(first_pll_enable), .second_pll_enable(second_pll_enable),
    .third_cfg(third_cfg), .fourth_cfg(fourth_cfg), .primary_clock_out(primary_clock_out),
    .secondary_clock_out(secondary_clock_out), .sync_out(sync_out),
    .lock_indicator(lock_indicator));

  // register model follows every accepted write
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      foreach (m[i]) m[i] = 0;
    end else if (ce && cfg_wr && cfg_addr < 5) begin
      m[cfg_addr] = cfg_wdata;
    end
  end

  task automatic finish_test();
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input int exp);
    n_tests++;
    if (seen !== 8'(exp)) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, 8'(exp));
    end
  endtask

  task automatic chk_all();
    int e1, e2, r4, sel, rev, lk;
    e1 = m[0] & 1;
    e2 = m[1] & 1;
    r4 = m[4];
    sel = r4 & 3;
    rev = !rfs && (m[0] >> 1) == 8;
    lk = (sel == 1) ? l1 : (sel == 2) ? l2 :
      (sel == 3) ? ((e1 | e2) && (l1 || !e1) && (l2 || !e2)) : 0;
    check(slave_mode, !rfs);
    check(rev_slave_mode, rev);
    check(mode_code, m[0] >> 1);
    check(multiplier, m[1] >> 1);
    check(first_pll_enable, e1);
    check(second_pll_enable, e2);
    check(third_cfg, rev ? 0 : m[2]);
    check(fourth_cfg, rev ? 0 : m[3]);
    check(primary_clock_out, c1 & e1 & (r4 >> 3));
    check(secondary_clock_out, c2 & e2 & (r4 >> 2));
    check(sync_out, sp & (r4 >> 4));
    check(lock_indicator, lk);
  endtask

  // pins settle in three edges, registers in two; six leaves margin
  task automatic settle();
    repeat (6) @(posedge core_clk);
    #1;
  endtask

  task automatic set_pins(input logic [5:0] v);
    @(posedge core_clk);
    {sp, c2, c1, l2, l1, rfs} <= v;
  endtask

  task automatic rd_chk(input int a);
    host.set_addr(3'(a));
    repeat (2) @(posedge core_clk);
    #1;
    check(cfg_rdata, a < 5 ? m[a] : 0);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    mismatches++;
    finish_test();
  end

  initial begin
    int a, d;
    arst_n = 1'b0;
    ce = 1'b1;
    {sp, c2, c1, l2, l1, rfs} = 6'h01;
    mismatches = 0;
    n_tests = 0;
    void'($urandom(6939));
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    settle();
    chk_all();
    for (a = 0; a < 8; a++) rd_chk(a);
    // slave bring-up with both loops locked and clocks high
    set_pins(6'h1e);
    host.rev_slave_setup();
    settle();
    chk_all();
    check({primary_clock_out, secondary_clock_out}, 3);
    // drivers off: toggling loop clocks must not pass through
    host.write_reg(ADDR_OUT_EN, 5'h00, 0);
    settle();
    for (a = 0; a < 8; a++) begin
      set_pins({a[0], a[0], a[0], 3'b110});
      #1;
      check({primary_clock_out, secondary_clock_out, sync_out}, 0);
    end
    // a write with the clock enable low is dropped
    @(posedge core_clk);
    ce <= 1'b0;
    host.write_reg(ADDR_OUT_EN, 5'h1f, 0);
    @(posedge core_clk);
    ce <= 1'b1;
    settle();
    chk_all();
    for (int i = 0; i < 200; i++) begin
      a = $urandom_range(7, 0);
      d = $urandom_range(63, 0);
      // favour the reverse/slave mode code on the mode register
      if (a == 0 && d > 31) d = 16 | (d & 1);
      set_pins(6'($urandom_range(63, 0)));
      host.write_reg(3'(a), 5'(d), $urandom_range(2, 0));
      settle();
      chk_all();
      rd_chk($urandom_range(7, 0));
    end
    finish_test();
  end
endmodule
